//--- apop_map.svh
// Constants of the converter output port: widths, latency, limits.
// Assumes inclusion by the package, the design files and the bench.
`ifndef APOP_MAP_SVH
`define APOP_MAP_SVH

`define APOP_WORD_W 12
`define APOP_LATENCY 6
`define APOP_CODE_MIN 12'h000
`define APOP_CODE_MAX 12'hFFF
`define APOP_RAW_W 14
`define APOP_CLK_MHZ 125
`define APOP_CONV_MIN_MHZ 1
`define APOP_CONV_TYP_MHZ 80

`endif

//--- apop_pkg.sv
// Types shared by the converter output port.
// Assumes the map header is on the include path.
`include "apop_map.svh"

package apop_pkg;
  typedef logic [`APOP_WORD_W-1:0] apop_word_t;
  typedef enum logic {APOP_ACTIVE, APOP_SLEEP} apop_mode_t;
endpackage : apop_pkg

//--- apop_delay_line.sv
// Fixed-depth pipeline delay line with valid bit; output from registers.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "apop_map.svh"

module apop_delay_line #(
  parameter int WIDTH = `APOP_WORD_W,
  parameter int DEPTH = `APOP_LATENCY
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Stage control
  input wire logic shift_en,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_word,
  // Delayed result
  output logic out_valid,
  output logic [WIDTH-1:0] out_word
);
  logic [WIDTH-1:0] word_q [DEPTH];
  logic [WIDTH-1:0] word_d [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;

  always_comb begin
    word_d = word_q;
    vld_d = vld_q;
    if (shift_en) begin
      word_d[0] = in_word;
      vld_d[0] = in_valid;
      for (int i = 1; i < DEPTH; i++) begin
        word_d[i] = word_q[i-1];
        vld_d[i] = vld_q[i-1];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        word_q[i] <= '0;
      end
      vld_q <= '0;
    end else begin
      word_q <= word_d;
      vld_q <= vld_d;
    end
  end

  assign out_word = word_q[DEPTH-1];
  assign out_valid = vld_q[DEPTH-1];
endmodule : apop_delay_line

`default_nettype wire

//--- apop_port.sv
// Digital output side of a pipelined 12-bit converter.
// Assumes conv_clk_in is a synchronous level sampled on core_clk.
//
// Contract
// R1: Sample taken on conversion clock rising edge
// R2: Partner keeps conversion clock 1 to 80 MHz
// R3: Enable low drives word, high floats
// R4: Sleep request high stops conversion
// R5: Offset binary twelve bits, bit0 LSB
// R6: Result emerges six conversion clocks later
// R7: One result every conversion clock cycle
// R8: Out-of-range inputs clamp to 0 or 4095
// R9: Partner registers word once per clock
`timescale 1ns/1ps
`default_nettype none
`include "apop_map.svh"

module apop_port #(
  parameter int LATENCY = `APOP_LATENCY
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Conversion clock and controls
  input wire logic conv_clk_in,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  // Signed raw sample from the analog front end, two's complement
  input wire logic signed [`APOP_RAW_W-1:0] raw_sample,
  // Parallel output bus
  output logic [`APOP_WORD_W-1:0] sample_word,
  output logic [`APOP_WORD_W-1:0] sample_word_oe,
  output logic sample_valid
);
  // ==========================================================
  // Edge detect and mode
  logic conv_clk_q;
  logic conv_clk_d;
  logic conv_edge;
  apop_pkg::apop_mode_t mode_q;
  apop_pkg::apop_mode_t mode_d;

  assign conv_edge = conv_clk_in & ~conv_clk_q; // [R1]

  always_comb begin
    conv_clk_d = conv_clk_in;
    mode_d = sleep_request ? apop_pkg::APOP_SLEEP : apop_pkg::APOP_ACTIVE; // [R4]
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      conv_clk_q <= 1'b0;
      mode_q <= apop_pkg::APOP_ACTIVE;
    end else begin
      conv_clk_q <= conv_clk_d;
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // Clamp and offset-binary code
  function automatic apop_pkg::apop_word_t to_code(
    input logic signed [`APOP_RAW_W-1:0] raw
  );
    logic signed [`APOP_RAW_W-1:0] lo;
    logic signed [`APOP_RAW_W-1:0] hi;
    logic signed [`APOP_RAW_W-1:0] sum;
    lo = -(`APOP_RAW_W'(1) <<< (`APOP_WORD_W-1));
    hi = (`APOP_RAW_W'(1) <<< (`APOP_WORD_W-1)) - `APOP_RAW_W'(1);
    if (raw < lo) begin
      to_code = `APOP_CODE_MIN; // [R8]
    end else if (raw > hi) begin
      to_code = `APOP_CODE_MAX; // [R8]
    end else begin
      sum = raw - lo; // [R5]
      to_code = sum[`APOP_WORD_W-1:0];
    end
  endfunction : to_code

  // Sleep stops new samples; the pipe holds still so stale words stay put.
  logic take;
  logic pipe_valid;
  logic [`APOP_WORD_W-1:0] pipe_word;
  assign take = conv_edge && (mode_q == apop_pkg::APOP_ACTIVE); // [R4] [R7]

  apop_delay_line #(
    .WIDTH(`APOP_WORD_W),
    .DEPTH(LATENCY)
  ) u_pipe (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .shift_en(take),
    .in_valid(1'b1),
    .in_word(to_code(raw_sample)),
    .out_valid(pipe_valid),
    .out_word(pipe_word)
  ); // [R6]

  // ==========================================================
  // Output drivers
  // Word leaves the last stage on the take that retires it: six edges old,
  // and no extra conversion edge is spent in this register.
  logic [`APOP_WORD_W-1:0] word_q;
  logic [`APOP_WORD_W-1:0] word_d;
  logic [`APOP_WORD_W-1:0] oe_q;
  logic [`APOP_WORD_W-1:0] oe_d;
  logic valid_q;
  logic valid_d;

  always_comb begin
    word_d = word_q;
    valid_d = 1'b0;
    if (take && pipe_valid) begin
      word_d = pipe_word; // [R6]
      valid_d = 1'b1; // [R7]
    end
    oe_d = out_enable_n ? '0 : '1; // [R3]
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      word_q <= '0;
      oe_q <= '0;
      valid_q <= 1'b0;
    end else begin
      word_q <= word_d;
      oe_q <= oe_d;
      valid_q <= valid_d;
    end
  end

  assign sample_word = word_q;
  assign sample_word_oe = oe_q;
  assign sample_valid = valid_q;

  // ==========================================================
  // Fill count for checks
  // Saturates at the latency; only the assertions read it.
  localparam int FILL_W = $clog2(LATENCY + 1);
  logic [FILL_W-1:0] fill_q;
  logic [FILL_W-1:0] fill_d;

  always_comb begin
    fill_d = fill_q;
    if (take && (fill_q != FILL_W'(LATENCY))) begin
      fill_d = fill_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fill_q <= '0;
    end else begin
      fill_q <= fill_d;
    end
  end

  // ==========================================================
  // Checks: output bus
  // Sampled reset in each |=> antecedent keeps the release edge quiet.
  a_oe_follows_pin: assert property (@(posedge core_clk) disable iff (!reset_n) // [R3]
    (reset_n && out_enable_n) |=> (sample_word_oe == '0))
    else $error("bus not floated");
  a_oe_drives_all: assert property (@(posedge core_clk) disable iff (!reset_n) // [R3]
    (reset_n && !out_enable_n) |=> (sample_word_oe == '1))
    else $error("bus not driven");
  a_oe_uniform: assert property (@(posedge core_clk) disable iff (!reset_n) // [R3]
    (sample_word_oe == '0) || (sample_word_oe == '1))
    else $error("bus half driven");
  a_word_from_pipe: assert property (@(posedge core_clk) disable iff (!reset_n) // [R6]
    (reset_n && take && pipe_valid) |=> (sample_word == $past(pipe_word)))
    else $error("word not from pipe");
  a_word_stable: assert property (@(posedge core_clk) disable iff (!reset_n) // [R6]
    !sample_valid |-> $stable(sample_word))
    else $error("word changed");

  // ==========================================================
  // Checks: conversion and sleep
  a_edge_only_take: assert property (@(posedge core_clk) disable iff (!reset_n) // [R1]
    take |-> (conv_clk_in && !conv_clk_q))
    else $error("take off edge");
  a_sleep_no_take: assert property (@(posedge core_clk) disable iff (!reset_n) // [R4]
    (mode_q == apop_pkg::APOP_SLEEP) |-> !take)
    else $error("converted asleep");
  a_mode_follows_pin: assert property (@(posedge core_clk) disable iff (!reset_n) // [R4]
    (reset_n && sleep_request) |=> (mode_q == apop_pkg::APOP_SLEEP))
    else $error("sleep not entered");
  a_mode_wakes: assert property (@(posedge core_clk) disable iff (!reset_n) // [R4]
    (reset_n && !sleep_request) |=> (mode_q == apop_pkg::APOP_ACTIVE))
    else $error("sleep not left");
  a_asleep_frozen: assert property (@(posedge core_clk) disable iff (!reset_n) // [R4]
    (reset_n && (mode_q == apop_pkg::APOP_SLEEP)) |=>
    ($stable(pipe_word) && !sample_valid))
    else $error("pipe moved asleep");

  // ==========================================================
  // Checks: latency and rate
  a_fill_before_out: assert property (@(posedge core_clk) disable iff (!reset_n) // [R6]
    (take && pipe_valid) |-> (fill_q == FILL_W'(LATENCY)))
    else $error("result too early");
  a_full_gives_out: assert property (@(posedge core_clk) disable iff (!reset_n) // [R6]
    (take && (fill_q == FILL_W'(LATENCY))) |-> pipe_valid)
    else $error("result too late");
  a_valid_on_edge: assert property (@(posedge core_clk) disable iff (!reset_n) // [R7]
    sample_valid |-> $past(take))
    else $error("result off edge");
  a_result_per_edge: assert property (@(posedge core_clk) disable iff (!reset_n) // [R7]
    (reset_n && take && pipe_valid) |=> sample_valid)
    else $error("result missing");
  a_valid_single: assert property (@(posedge core_clk) disable iff (!reset_n) // [R7]
    (reset_n && sample_valid) |=> !sample_valid)
    else $error("valid too long");

  // ==========================================================
  // Checks: code
  a_clamp_high: assert property (@(posedge core_clk) disable iff (!reset_n) // [R8]
    (raw_sample > 14'sd2047) |-> (to_code(raw_sample) == `APOP_CODE_MAX))
    else $error("no high clamp");
  a_clamp_low: assert property (@(posedge core_clk) disable iff (!reset_n) // [R8]
    (raw_sample < -14'sd2048) |-> (to_code(raw_sample) == `APOP_CODE_MIN))
    else $error("no low clamp");
  a_zero_midscale: assert property (@(posedge core_clk) disable iff (!reset_n) // [R5]
    (raw_sample == 14'sd0) |-> (to_code(raw_sample) == 12'h800))
    else $error("offset wrong");
endmodule : apop_port

`default_nettype wire

//--- apop_cap_model.sv
// Capture-side partner: makes conv clock, registers words.
// Assumes the port samples conv_clk on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "apop_map.svh"
module apop_cap_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic [3:0] half,
  // Converter side
  output logic conv_clk,
  input wire logic [`APOP_WORD_W-1:0] sample_word,
  input wire logic sample_valid,
  // Captured result
  output logic [`APOP_WORD_W-1:0] cap_word,
  output logic cap_stb
);
  logic [3:0] cnt_q;
  // Clock stands low between bursts
  always_ff @(posedge core_clk) begin
    if (!reset_n || (!run && !conv_clk)) begin
      cnt_q <= 4'h0;
      conv_clk <= 1'b0;
    end else if (cnt_q + 4'h1 >= half) begin
      cnt_q <= 4'h0;
      conv_clk <= ~conv_clk;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    cap_stb <= sample_valid;
    if (sample_valid) cap_word <= sample_word;
  end
endmodule : apop_cap_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the converter output port.
// Assumes design files and map header on the compile path.
`timescale 1ns/1ps
`default_nettype none
`include "apop_map.svh"
module tb_top;
  logic core_clk, reset_n, out_enable_n, sleep_request, run, conv_clk;
  logic signed [`APOP_RAW_W-1:0] raw_sample;
  logic [11:0] sample_word, sample_word_oe, cap_word;
  logic sample_valid, cap_stb, conv_q, slp_q;
  logic [3:0] half;
  logic [11:0] exp_q[$];
  int err_total, comparisons, takes, results, cycles;
  apop_port i_apop_port (.core_clk(core_clk), .reset_n(reset_n), .conv_clk_in(conv_clk),
    .out_enable_n(out_enable_n), .sleep_request(sleep_request), .raw_sample(raw_sample),
    .sample_word(sample_word), .sample_word_oe(sample_word_oe), .sample_valid(sample_valid));
  apop_cap_model i_apop_cap_model (.core_clk(core_clk), .reset_n(reset_n), .run(run),
    .half(half), .conv_clk(conv_clk), .sample_word(sample_word),
    .sample_valid(sample_valid), .cap_word(cap_word), .cap_stb(cap_stb));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  function automatic logic [11:0] code(input int r);
    return (r < -2048) ? 12'h000 : (r > 2047) ? 12'hfff : 12'(r + 2048);
  endfunction : code
  task automatic test_done();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // ==========
  // Monitor: record each taken edge, compare each capture
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 5000) begin
      err_total++;
      test_done();
    end else begin
      conv_q <= conv_clk;
      slp_q <= sleep_request;
      if (reset_n && conv_clk && !conv_q && !slp_q) begin
        takes <= takes + 1;
        exp_q.push_back(code(raw_sample));
      end
      if (cap_stb) begin
        results <= results + 1;
        check(cap_word, exp_q.pop_front());
      end
    end
  end
  task automatic wait_takes(input int n);
    int t0;
    t0 = takes;
    for (int i = 0; i < 200 && takes < t0 + n; i++) @(posedge core_clk);
  endtask : wait_takes
  // ==========
  // Scenarios
  task automatic t_oe();
    out_enable_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(sample_word_oe, 12'h000);
    out_enable_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(sample_word_oe, 12'hfff);
    $display("test oe done");
  endtask : t_oe
  task automatic t_stream();
    int vals[8] = '{-3000, -2048, -1, 0, 5, 2047, 3000, 1234};
    half <= 4'h1;
    run <= 1'b1;
    foreach (vals[i]) begin
      raw_sample <= `APOP_RAW_W'(vals[i]);
      wait_takes(1);
    end
    wait_takes(6);
    run <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(12'(takes - results), 12'h006);
    $display("test stream done");
  endtask : t_stream
  task automatic t_sleep();
    int r0;
    r0 = results;
    half <= 4'h3;
    sleep_request <= 1'b1;
    @(posedge core_clk);
    run <= 1'b1;
    repeat (40) @(posedge core_clk);
    run <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(12'(results - r0), 12'h000);
    sleep_request <= 1'b0;
    @(posedge core_clk);
    run <= 1'b1;
    wait_takes(3);
    run <= 1'b0;
    repeat (12) @(posedge core_clk);
    check(12'(results - r0), 12'h003);
    $display("test sleep done");
  endtask : t_sleep
  initial begin
    reset_n = 1'b0;
    out_enable_n = 1'b0;
    sleep_request = 1'b0;
    run = 1'b0;
    half = 4'h2;
    raw_sample = '0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_oe();
    t_stream();
    t_sleep();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
